// File: src/fifo_flags.sv
/*
 Dual-clock FIFO with status flags, two timing modes and programmable offsets.
 Assumes the write and read clocks are much slower than hclk; both are sampled
 and edge-detected here, so all state lives in the hclk domain.
*/
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
// Functional notes
// - Mode pin sampled at reset: low registered-read, high fall-through.
// - Fall-through first word appears after three read-clock edges, no read enable.
// - Write data captured at write-clock edge with write enable low, unless full.
// - Registered-read: empty flag rises after first write; almost-empty high at n+1.
// - Registered-read half-full low at half depth plus one words.
// - Registered-read almost-full low at depth minus m words.
// - Registered-read full flag low at depth words; writes ignored meanwhile.
// - Registered-read drain: full releases, almost-empty low at n, reads ignored empty.
// - Registered-read empty and full flags pass two stages in own domain.
// - Fall-through output-ready low after first write; almost-empty high at n+2.
// - Fall-through half-full low at half depth plus two words.
// - Fall-through almost-full low at depth plus one minus m words.
// - Fall-through input-ready high, blocking writes, at depth plus one words.
// - Fall-through drain: input-ready low, almost-empty low at n+1, ready high.
// - Fall-through output-ready three stages, input-ready two stages.
// - Offset-load high at reset: serial loading, both offsets 3FF.
// - Offset-load low at reset: parallel loading, both offsets 07F.
// - Offsets read back by the parallel read method or at the bus offset registers.
// - Offsets may be reprogrammed at any time after reset.
// - Serial shift one bit per write-clock edge, empty offset LSB first.
// - Parallel load writes empty, then full, then empty offset again.
// - Reset puts both offset pointers on the empty offset.
// - Almost flags held as invalid until every serial bit is in.
module fifo_flags #(
    parameter int AW = fifo_pkg::ADDR_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic write_clk,
    input wire logic read_clk,
    input wire logic write_en_n,
    input wire logic read_en_n,
    input wire logic offset_load_n,
    input wire logic serial_enable_n,
    input wire logic mode_or_serial_in,
    input wire logic [fifo_pkg::DATA_W-1:0] write_data,
    output logic [fifo_pkg::DATA_W-1:0] data_out,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic half_full_n,
    output logic almost_empty_n,
    output logic almost_full_n
);
    localparam int TW = AW + 2;
    localparam int SW = 2 * AW;
    localparam logic [TW-1:0] DEPTH = TW'(1 << AW);
    localparam logic [TW-1:0] HALF = TW'(1 << (AW - 1));

    function automatic logic [TW-1:0] ext(input logic [AW-1:0] v);
        ext = {2'h0, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling and edge detection
    logic [fifo_pkg::PIN_W-1:0] pins_s;
    logic wclk_s, rclk_s, wen_n_s, ren_n_s, ld_n_s, sen_n_s, si_s;
    logic [fifo_pkg::DATA_W-1:0] wdata_s;
    logic wclk_d_r, rclk_d_r, w_edge, r_edge;

    pin_sync #(.W(fifo_pkg::PIN_W)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .d({write_clk, read_clk, write_en_n, read_en_n, offset_load_n, serial_enable_n, mode_or_serial_in,
            write_data}),
        .q(pins_s)
    );
    assign {wclk_s, rclk_s, wen_n_s, ren_n_s, ld_n_s, sen_n_s, si_s, wdata_s} = pins_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wclk_d_r <= 1'b0;
            rclk_d_r <= 1'b0;
        end else if (ce) begin
            wclk_d_r <= wclk_s;
            rclk_d_r <= rclk_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture after reset release
    logic [1:0] cfg_cnt_r;
    logic cfg_done_r, fall_through_mode_r, serial_r;

    assign w_edge = cfg_done_r && wclk_s && !wclk_d_r;
    assign r_edge = cfg_done_r && rclk_s && !rclk_d_r;

    // Straps are read through the synchroniser, so wait until it has filled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_cnt_r <= 2'h0;
            cfg_done_r <= 1'b0;
            fall_through_mode_r <= 1'b0;
            serial_r <= 1'b0;
        end else if (ce && !cfg_done_r) begin
            cfg_cnt_r <= cfg_cnt_r + 2'h1;
            if (cfg_cnt_r == fifo_pkg::CFG_WAIT) begin
                cfg_done_r <= 1'b1;
                fall_through_mode_r <= si_s;
                serial_r <= ld_n_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offset registers
    logic [AW-1:0] eoff_r, foff_r;
    logic owp_r, orp_r;
    logic [AW:0] ser_cnt_r;
    logic ser_busy, ser_go, par_wr, par_rd, bus_we_r;
    logic [7:0] bus_addr_r;

    assign ser_go = w_edge && serial_r && !ld_n_s && !sen_n_s && wen_n_s;
    assign par_wr = w_edge && !serial_r && !ld_n_s && !wen_n_s;
    assign par_rd = r_edge && !ld_n_s && !ren_n_s;
    assign ser_busy = (ser_cnt_r != '0) && (ser_cnt_r != (AW+1)'(SW));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eoff_r <= fifo_pkg::OFF_PARALLEL_DEF[AW-1:0];
            foff_r <= fifo_pkg::OFF_PARALLEL_DEF[AW-1:0];
            owp_r <= 1'b0;
            orp_r <= 1'b0;
            ser_cnt_r <= '0;
        end else if (ce) begin
            if (!cfg_done_r && cfg_cnt_r == fifo_pkg::CFG_WAIT) begin
                eoff_r <= ld_n_s ? fifo_pkg::OFF_SERIAL_DEF[AW-1:0] : fifo_pkg::OFF_PARALLEL_DEF[AW-1:0];
                foff_r <= ld_n_s ? fifo_pkg::OFF_SERIAL_DEF[AW-1:0] : fifo_pkg::OFF_PARALLEL_DEF[AW-1:0];
            end else if (ser_go) begin
                {foff_r, eoff_r} <= {si_s, foff_r, eoff_r[AW-1:1]};
                ser_cnt_r <= (ser_cnt_r == (AW+1)'(SW)) ? (AW+1)'(1) : ser_cnt_r + (AW+1)'(1);
            end else if (par_wr) begin
                if (owp_r) begin
                    foff_r <= wdata_s[AW-1:0];
                end else begin
                    eoff_r <= wdata_s[AW-1:0];
                end
                owp_r <= ~owp_r;
            end else if (bus_we_r && cfg_done_r) begin
                // Bus loads are the lower priority path into the same registers
                if (bus_addr_r == fifo_pkg::EMPTY_OFF_ADDR) begin
                    eoff_r <= hwdata[AW-1:0];
                end else if (bus_addr_r == fifo_pkg::FULL_OFF_ADDR) begin
                    foff_r <= hwdata[AW-1:0];
                end
            end
            if (par_rd) begin
                orp_r <= ~orp_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage and counting
    logic [AW-1:0] wptr_r, rptr_r;
    logic [TW-1:0] cnt_r, tot;
    logic ov_r;
    logic [1:0] fall_r;
    logic wr_go, rd_go, ft_read, ft_load, mem_rd;
    logic [fifo_pkg::DATA_W-1:0] ram_q;

    assign tot = cnt_r + TW'(ov_r);
    assign wr_go = w_edge && !wen_n_s && ld_n_s && (cnt_r != DEPTH);
    assign rd_go = !fall_through_mode_r && r_edge && !ren_n_s && ld_n_s && (cnt_r != '0);
    assign ft_read = fall_through_mode_r && r_edge && !ren_n_s && ld_n_s && ov_r;
    assign ft_load = fall_through_mode_r && (cnt_r != '0) && (ft_read || (r_edge && !ov_r && fall_r[1]));
    assign mem_rd = rd_go || ft_load;

    fifo_ram #(.AW(AW), .DW(fifo_pkg::DATA_W)) u_ram (
        .hclk(hclk),
        .we(wr_go && ce),
        .waddr(wptr_r),
        .wdata(wdata_s),
        .raddr(rptr_r),
        .rdata(ram_q)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            if (wr_go) begin
                wptr_r <= wptr_r + AW'(1);
            end
            if (mem_rd) begin
                rptr_r <= rptr_r + AW'(1);
            end
            cnt_r <= cnt_r + TW'(wr_go) - TW'(mem_rd);
        end
    end

    // Two stages of read-clock delay, the output word itself is the third
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ov_r <= 1'b0;
            fall_r <= 2'h0;
            data_out <= '0;
        end else if (ce) begin
            if (r_edge) begin
                fall_r <= {fall_r[0], cnt_r != '0};
            end
            if (ft_load) begin
                ov_r <= 1'b1;
            end else if (ft_read) begin
                ov_r <= 1'b0;
                fall_r <= 2'h0;
            end
            if (mem_rd) begin
                data_out <= ram_q;
            end else if (par_rd) begin
                data_out <= fifo_pkg::DATA_W'(orp_r ? foff_r : eoff_r);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags
    logic [fifo_pkg::STD_FLAG_STAGES-1:0] ef_st_r;
    logic [fifo_pkg::FT_IR_STAGES-1:0] ff_st_r;
    logic full_raw, ae_raw, af_raw, hf_raw;

    assign full_raw = fall_through_mode_r ? (tot == DEPTH + TW'(1)) : (cnt_r == DEPTH);
    assign ae_raw = fall_through_mode_r ? (tot < ext(eoff_r) + TW'(2)) : (tot < ext(eoff_r) + TW'(1));
    assign af_raw = fall_through_mode_r ? (tot >= DEPTH + TW'(1) - ext(foff_r)) : (tot >= DEPTH - ext(foff_r));
    assign hf_raw = fall_through_mode_r ? (tot >= HALF + TW'(2)) : (tot >= HALF + TW'(1));

    // Flags other than half-full move only on the edges of the port they guard
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ef_st_r <= '0;
            empty_flag_n <= 1'b0;
            almost_empty_n <= 1'b0;
        end else if (ce) begin
            if (!cfg_done_r) begin
                empty_flag_n <= 1'b0;
            end else if (fall_through_mode_r) begin
                empty_flag_n <= ~ov_r;
            end else begin
                empty_flag_n <= ef_st_r[fifo_pkg::STD_FLAG_STAGES-1];
            end
            if (r_edge) begin
                ef_st_r <= {ef_st_r[0], cnt_r != '0};
                if (!ser_busy) begin
                    almost_empty_n <= ~ae_raw;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ff_st_r <= '0;
            full_flag_n <= 1'b1;
            almost_full_n <= 1'b1;
        end else if (ce) begin
            // Input-ready idles low in fall-through mode, full idles high otherwise
            full_flag_n <= fall_through_mode_r ? ff_st_r[fifo_pkg::FT_IR_STAGES-1] : ~ff_st_r[fifo_pkg::STD_FLAG_STAGES-1];
            if (w_edge) begin
                ff_st_r <= {ff_st_r[0], full_raw};
                if (!ser_busy) begin
                    almost_full_n <= ~af_raw;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_full_n <= 1'b1;
        end else if (ce) begin
            half_full_n <= ~hf_raw;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    logic [31:0] rd_mux;
    logic [7:0] status;

    assign status = {ov_r, serial_r, fall_through_mode_r, almost_full_n, almost_empty_n, half_full_n, full_flag_n,
                     empty_flag_n};

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (haddr[7:0] == fifo_pkg::STATUS_ADDR) begin
            rd_mux = {24'h00_0000, status};
        end else if (haddr[7:0] == fifo_pkg::EMPTY_OFF_ADDR) begin
            rd_mux = 32'(eoff_r);
        end else if (haddr[7:0] == fifo_pkg::FULL_OFF_ADDR) begin
            rd_mux = 32'(foff_r);
        end else if (haddr[7:0] == fifo_pkg::COUNT_ADDR) begin
            rd_mux = 32'(tot);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_we_r <= 1'b0;
            bus_addr_r <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            bus_we_r <= 1'b0;
            if (hsel && hready && htrans == fifo_pkg::HTRANS_NONSEQ) begin
                bus_we_r <= hwrite && (haddr[31:8] == 24'h00_0000);
                bus_addr_r <= haddr[7:0];
                hrdata <= (haddr[31:8] == 24'h00_0000) ? rd_mux : 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence load_done_s;
        ce && !cfg_done_r && cfg_cnt_r == fifo_pkg::CFG_WAIT;
    endsequence

    mode_strap_a: assert property (load_done_s |=> fall_through_mode_r == $past(si_s))
        else $error("mode not taken from strap");
    serial_def_a: assert property (load_done_s ##0 ld_n_s |=> eoff_r == fifo_pkg::OFF_SERIAL_DEF[AW-1:0])
        else $error("serial default offset wrong");
    par_def_a: assert property (load_done_s ##0 !ld_n_s |=> foff_r == fifo_pkg::OFF_PARALLEL_DEF[AW-1:0])
        else $error("parallel default offset wrong");
    no_overfill_a: assert property (ce && cnt_r == DEPTH && !mem_rd |=> cnt_r == DEPTH)
        else $error("write accepted while full");
    empty_read_a: assert property (ce && tot == '0 |=> $stable(data_out) || $past(par_rd))
        else $error("read taken while empty");
    fall_three_a: assert property (ce && fall_through_mode_r && $rose(ov_r) |-> $past(fall_r[1]) || $past(ft_read))
        else $error("word fell through early");
    ptr_toggle_a: assert property (ce && par_wr |=> owp_r != $past(owp_r))
        else $error("offset write pointer stuck");
    // Two read edges that both saw an empty store must leave the flag low
    sequence ef_idle_s;
        ce && !fall_through_mode_r && cfg_done_r && r_edge && cnt_r == '0 && !ef_st_r[0];
    endsequence

    ef_stage_a: assert property (ef_idle_s ##1 ce |=> !empty_flag_n)
        else $error("empty flag not low after two read edges");
    hf_std_a: assert property (ce && !fall_through_mode_r && cfg_done_r && tot >= HALF + TW'(1) |=> !half_full_n)
        else $error("half-full not asserted");
    ae_hold_a: assert property (ce && ser_busy |=> $stable(almost_empty_n))
        else $error("almost-empty moved during serial load");
endmodule

// File: src/fifo_pkg.sv
/*
 Shared constants for the dual-clock flag FIFO: widths, flag stage counts,
 offset defaults, bus register map and status bit layout.
 Assumes a 32-bit AHB-Lite bus and one system clock that samples both port clocks.
*/
package fifo_pkg;
    localparam int DATA_W = 18;
    localparam int ADDR_W = 15;
    localparam int PIN_W = 7 + DATA_W;
    localparam logic [15:0] OFF_SERIAL_DEF = 16'h03FF;
    localparam logic [15:0] OFF_PARALLEL_DEF = 16'h007F;
    localparam logic [1:0] CFG_WAIT = 2'h2;
    localparam int STD_FLAG_STAGES = 2;
    localparam int FT_OR_STAGES = 3;
    localparam int FT_IR_STAGES = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [7:0] STATUS_ADDR = 8'h00;
    localparam logic [7:0] EMPTY_OFF_ADDR = 8'h04;
    localparam logic [7:0] FULL_OFF_ADDR = 8'h08;
    localparam logic [7:0] COUNT_ADDR = 8'h0C;
    localparam int ST_EMPTY = 0;
    localparam int ST_FULL = 1;
    localparam int ST_HALF = 2;
    localparam int ST_AEMPTY = 3;
    localparam int ST_AFULL = 4;
    localparam int ST_FT = 5;
    localparam int ST_SERIAL = 6;
    localparam int ST_OUTV = 7;
endpackage

// File: src/pin_sync.sv
/*
 Two-stage synchroniser for a bundle of pins.
 Assumes the first stage is read by the second stage only.
*/
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= '0;
            q <= '0;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// File: src/fifo_ram.sv
/*
 Word store of the FIFO: one write port, one asynchronous read port.
 Assumes the caller never reads and writes the same word in one cycle.
*/
`timescale 1ns/100ps
module fifo_ram #(
    parameter int AW = 15,
    parameter int DW = 18
) (
    input wire logic hclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule

// File: verification/fifo_port_peer.sv
/*
 Writer and reader logic on the two port clocks of the flag FIFO.
 Assumes hclk is the bench clock; port clocks toggle only inside op calls.
*/
`timescale 1ns/100ps
module fifo_port_peer (
    input wire logic hclk,
    output logic write_clk,
    output logic read_clk,
    output logic write_en_n,
    output logic read_en_n,
    output logic offset_load_n,
    output logic serial_enable_n,
    output logic mode_or_serial_in,
    output logic [fifo_pkg::DATA_W-1:0] write_data
);
    initial begin
        write_clk = 1'b0;
        read_clk = 1'b0;
        write_en_n = 1'b1;
        read_en_n = 1'b1;
        offset_load_n = 1'b1;
        serial_enable_n = 1'b1;
        mode_or_serial_in = 1'b0;
        write_data = 18'h00000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Straps stay put from reset until well after release
    task automatic strap(input bit mode, input bit ld_n);
        mode_or_serial_in <= mode;
        offset_load_n <= ld_n;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One frame: both port clocks rise once; enables lead the rise by 2 hclk, 320 ns a frame
    task automatic op(input bit we, input bit re, input bit ld, input logic [17:0] d);
        write_en_n <= ~we;
        read_en_n <= ~re;
        offset_load_n <= ~ld;
        write_data <= d;
        repeat (2) @(posedge hclk);
        write_clk <= 1'b1;
        read_clk <= 1'b1;
        repeat (4) @(posedge hclk);
        write_clk <= 1'b0;
        read_clk <= 1'b0;
        write_en_n <= 1'b1;
        read_en_n <= 1'b1;
        offset_load_n <= 1'b1;
        // Released data lines show a changed value so a stale word cannot pass
        write_data <= ~d;
        repeat (2) @(posedge hclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Serial offset shift, one bit a frame; enable stays low across the bits
    task automatic ser_load(input logic [31:0] bits, input int n);
        serial_enable_n <= 1'b0;
        for (int k = 0; k < n; k++) begin
            mode_or_serial_in <= bits[k];
            op(1'b0, 1'b0, 1'b1, 18'h00000);
        end
        serial_enable_n <= 1'b1;
    endtask
endmodule

// File: verification/dual_clock_fifo_flag_logic_tb_top.sv
/*
 Self-checking bench of the flag FIFO: bus reads of status and offsets, port
 traffic through the peer model. Assumes AW=4, a depth of 16 words.
*/
`timescale 1ns/100ps
`define CHK(name, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got); \
        end \
    end
module dual_clock_fifo_flag_logic_tb_top;
    localparam int AW = 4;
    localparam int DEPTH = 16;
    localparam int NOFF = 2;
    localparam int MOFF = 3;
    localparam logic [31:0] OMASK = 32'h0000000F;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic write_clk, read_clk, write_en_n, read_en_n, offset_load_n, serial_enable_n, mode_or_serial_in;
    logic [17:0] write_data, data_out;
    logic empty_flag_n, full_flag_n, half_full_n, almost_empty_n, almost_full_n;
    logic [4:0] flagv;
    logic [3:0] ftv;
    logic ce;
    int bad_count, total_checks;
    assign flagv = {empty_flag_n, full_flag_n, half_full_n, almost_empty_n, almost_full_n};
    assign ftv = {half_full_n, full_flag_n, almost_empty_n, almost_full_n};
    always #20 hclk = ~hclk;
    fifo_flags #(.AW(AW)) u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .write_clk(write_clk), .read_clk(read_clk),
        .write_en_n(write_en_n), .read_en_n(read_en_n), .offset_load_n(offset_load_n),
        .serial_enable_n(serial_enable_n), .mode_or_serial_in(mode_or_serial_in), .write_data(write_data),
        .data_out(data_out), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .half_full_n(half_full_n), .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n));
    fifo_port_peer u_peer (.hclk(hclk), .write_clk(write_clk), .read_clk(read_clk), .write_en_n(write_en_n),
        .read_en_n(read_en_n), .offset_load_n(offset_load_n), .serial_enable_n(serial_enable_n),
        .mode_or_serial_in(mode_or_serial_in), .write_data(write_data));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] std_flags(input int c);
        std_flags = {c != 0, c != DEPTH, !(c >= DEPTH / 2 + 1), c >= NOFF + 1, !(c >= DEPTH - MOFF)};
    endfunction
    function automatic logic [3:0] ft_flags(input int h);
        ft_flags = {!(h >= DEPTH / 2 + 2), h >= DEPTH + 1, h >= NOFF + 2, !(h >= DEPTH + 1 - MOFF)};
    endfunction
    // Single AHB-Lite transfer; entered just after a rising edge
    task automatic ahb(input bit wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
        hsel <= 1'b1;
        htrans <= fifo_pkg::HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask
    // Three idle frames let flags cross into both port domains
    task automatic settle;
        repeat (3) u_peer.op(1'b0, 1'b0, 1'b0, 18'h00000);
    endtask
    task automatic do_reset(input bit mode, input bit ld_n);
        u_peer.strap(mode, ld_n);
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        ce = 1'b1;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        do_reset(1'b0, 1'b0);
        `CHK("reset flags", std_flags(0), flagv);
        ahb(1'b0, fifo_pkg::STATUS_ADDR, 32'h0, rd);
        `CHK("mode bit", 1'b0, rd[fifo_pkg::ST_FT]);
        ahb(1'b0, fifo_pkg::EMPTY_OFF_ADDR, 32'h0, rd);
        `CHK("empty offset", {16'h0000, fifo_pkg::OFF_PARALLEL_DEF} & OMASK, rd);
        ahb(1'b0, fifo_pkg::FULL_OFF_ADDR, 32'h0, rd);
        `CHK("full offset", {16'h0000, fifo_pkg::OFF_PARALLEL_DEF} & OMASK, rd);
        ahb(1'b0, 8'h10, 32'h0, rd);
        `CHK("unmapped", 32'h00000000, rd);
        `CHK("bus response", 1'b0, hresp);
        $display("test defaults done");
        // Third load wraps back onto the empty offset
        u_peer.op(1'b1, 1'b0, 1'b1, 18'h00005);
        u_peer.op(1'b1, 1'b0, 1'b1, 18'(MOFF));
        u_peer.op(1'b1, 1'b0, 1'b1, 18'(NOFF));
        ahb(1'b0, fifo_pkg::EMPTY_OFF_ADDR, 32'h0, rd);
        `CHK("empty offset", 32'(NOFF), rd);
        ahb(1'b0, fifo_pkg::FULL_OFF_ADDR, 32'h0, rd);
        `CHK("full offset", 32'(MOFF), rd);
        u_peer.op(1'b0, 1'b1, 1'b1, 18'h00000);
        settle();
        `CHK("offset readback", 18'(NOFF), data_out);
        $display("test offsets done");
        // Last write lands on a full buffer and must be dropped
        for (int i = 1; i <= DEPTH + 1; i++) begin
            u_peer.op(1'b1, 1'b0, 1'b0, 18'h2A000 + 18'(i));
            settle();
            `CHK("fill flags", std_flags(i > DEPTH ? DEPTH : i), flagv);
        end
        ahb(1'b0, fifo_pkg::COUNT_ADDR, 32'h0, rd);
        `CHK("count full", 32'(DEPTH), rd);
        for (int i = 1; i <= DEPTH + 1; i++) begin
            u_peer.op(1'b0, 1'b1, 1'b0, 18'h00000);
            settle();
            `CHK("read word", 18'h2A000 + 18'(i > DEPTH ? DEPTH : i), data_out);
            `CHK("drain flags", std_flags(i > DEPTH ? 0 : DEPTH - i), flagv);
        end
        ahb(1'b0, fifo_pkg::COUNT_ADDR, 32'h0, rd);
        `CHK("count empty", 32'h00000000, rd);
        // Port frames while the clock enable is low must leave no trace
        ce <= 1'b0;
        u_peer.op(1'b1, 1'b0, 1'b0, 18'h00033);
        ce <= 1'b1;
        ahb(1'b0, fifo_pkg::COUNT_ADDR, 32'h0, rd);
        `CHK("frozen count", 32'h00000000, rd);
        $display("test registered_read done");
        do_reset(1'b1, 1'b1);
        ahb(1'b0, fifo_pkg::STATUS_ADDR, 32'h0, rd);
        `CHK("mode bit", 1'b1, rd[fifo_pkg::ST_FT]);
        ahb(1'b0, fifo_pkg::EMPTY_OFF_ADDR, 32'h0, rd);
        `CHK("empty offset", {16'h0000, fifo_pkg::OFF_SERIAL_DEF} & OMASK, rd);
        u_peer.ser_load(32'((MOFF << AW) | NOFF), 2 * AW);
        ahb(1'b0, fifo_pkg::EMPTY_OFF_ADDR, 32'h0, rd);
        `CHK("serial empty offset", 32'(NOFF), rd);
        ahb(1'b0, fifo_pkg::FULL_OFF_ADDR, 32'h0, rd);
        `CHK("serial full offset", 32'(MOFF), rd);
        u_peer.op(1'b1, 1'b0, 1'b0, 18'h15001);
        settle();
        `CHK("first word", 18'h15001, data_out);
        `CHK("output ready", 1'b0, empty_flag_n);
        for (int i = 2; i <= DEPTH + 2; i++) begin
            u_peer.op(1'b1, 1'b0, 1'b0, 18'h15000 + 18'(i));
            settle();
            `CHK("ft flags", ft_flags(i > DEPTH + 1 ? DEPTH + 1 : i), ftv);
        end
        u_peer.op(1'b0, 1'b1, 1'b0, 18'h00000);
        settle();
        `CHK("second word", 18'h15002, data_out);
        `CHK("input ready", 1'b0, full_flag_n);
        // Seventeen reads: fifteen empty the store, the sixteenth the output word, the last finds it empty and is ignored
        for (int i = 1; i <= DEPTH + 1; i++) u_peer.op(1'b0, 1'b1, 1'b0, 18'h00000);
        settle();
        `CHK("last word", 18'h15000 + 18'(DEPTH + 1), data_out);
        `CHK("drained ft flags", {1'b1, ft_flags(0)}, {empty_flag_n, ftv});
        $display("test fall_through done");
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        end_sim();
    end
endmodule
